// ### hw/ipc_power_ctrl.sv
`timescale 1ns/10ps
module ipc_power_ctrl
    import ipc_pkg::*;
(
    // Clock and reset.
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    // Power control register access from the CPU core.
    input  wire ipc_pcr_wr_t pcr_wr_i,
    output logic [7:0]       pcr_rdata_o,
    // CPU core handshake.
    input  wire logic        instr_done_i,
    output logic             cpu_halt_o,
    output logic             periph_gate_o,
    // Interrupt controller.
    input  wire ipc_wake_t   wake_i,
    input  wire logic        glob_en_i,
    output logic             irq_release_o,
    // Status.
    output logic             idle_o
);

    ipc_state_t state;
    ipc_state_t next_state;
    logic [7:0] pcr;
    logic [7:0] next_pcr;
    logic       wake;
    logic       set_idle;
    logic       halt_q;

    // State decode shared by the halt flop and the status output, so the
    // two can never disagree about what counts as idle.
    function automatic logic in_idle(input ipc_state_t s);
        return s == IPC_IDLE;
    endfunction

    // Combined wake request from the enabled sources.
    ipc_wake_detect ipc_wake_detect_i (
        .wake_i    (wake_i),
        .glob_en_i (glob_en_i),
        .wake_o    (wake)
    );

    // The write is taken as the setting instruction completes. A write
    // that lands before the instruction ends is stored but does not halt
    // the core; software has to repeat it.
    assign set_idle = pcr_wr_i.we & pcr_wr_i.wdata[IPC_IDLE_BIT]
                    & instr_done_i;

    // Sequencer: RUN to IDLE on the write, IDLE to WAKE on an interrupt.
    // WAKE lasts one cycle; the core restarts in it, in the same cycle that the
    // interrupt controller sees the release; it then vectors and returns normally.
    always_comb begin
        next_state = state;
        case (state)
            IPC_RUN: begin
                if (set_idle) begin
                    next_state = IPC_IDLE;
                end
            end
            IPC_IDLE: begin
                if (wake) begin
                    next_state = IPC_WAKE;
                end
            end
            IPC_WAKE: next_state = IPC_RUN;
            default:  next_state = IPC_RUN;
        endcase
    end

    // Register update; the idle bit drops as the release cycle ends so the core does
    // not fall straight back into idle on return.
    always_comb begin
        next_pcr = pcr;
        if (pcr_wr_i.we) begin
            next_pcr = pcr_wr_i.wdata;
        end
        if (state == IPC_WAKE) begin
            next_pcr[IPC_IDLE_BIT] = 1'b0;
        end
    end

    // State and register flops; reset also clears the idle bit.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= IPC_RUN;
            pcr   <= IPC_PCR_RESET;
        end else begin
            state <= next_state;
            pcr   <= next_pcr;
        end
    end

    // Registered halt so the core sees a glitch-free stop.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            halt_q <= 1'b0;
        end else begin
            halt_q <= in_idle(next_state);
        end
    end

    // Outputs: halt stops fetch, gate shuts peripheral clocks.
    assign cpu_halt_o    = halt_q;
    assign periph_gate_o = halt_q;
    assign idle_o        = in_idle(state);
    assign irq_release_o = (state == IPC_WAKE);
    assign pcr_rdata_o   = pcr;

    // Idle is entered the cycle after the setting write.
    enter_idle_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (state == IPC_RUN && set_idle) |=> idle_o && cpu_halt_o)
        else $error("Idle not entered after the setting write.");

    // Idle holds while no wake is pending.
    hold_idle_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (idle_o && !wake) |=> idle_o)
        else $error("Idle left without a wake.");

    // A wake releases the core within two cycles.
    wake_exit_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (idle_o && wake) |=> irq_release_o ##1 !cpu_halt_o)
        else $error("Wake did not release the core.");

    // Halt and gate are on exactly while idle.
    halt_idle_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        cpu_halt_o == idle_o && periph_gate_o == idle_o)
        else $error("Halt does not match idle.");

    // The idle bit is clear from the cycle after the release.
    bit_clear_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        irq_release_o |=> !pcr_rdata_o[IPC_IDLE_BIT] && !idle_o)
        else $error("Idle bit still set after wake.");

    // Release lasts a single cycle and returns to run.
    release_one_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        irq_release_o |=> !irq_release_o && state == IPC_RUN)
        else $error("Release longer than one cycle.");

    // The write to the idle bit stores it.
    bit_store_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (set_idle && state == IPC_RUN) |=> pcr_rdata_o[IPC_IDLE_BIT])
        else $error("Idle bit not stored.");

    // Idle is entered only from the run state after a write.
    only_write_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        $rose(idle_o) |-> $past(set_idle))
        else $error("Idle entered without a write.");

    // Reset leaves the core running with the idle bit clear. No disable
    // here: the check looks at the first edge after reset is released.
    reset_clear_a: assert property (
        @(posedge clock_i)
        $rose(rst_n_i) |-> pcr_rdata_o == IPC_PCR_RESET && !idle_o)
        else $error("Reset left the idle request behind.");

    // Only a wake seen in idle can start the release pulse.
    release_cause_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        irq_release_o |-> $past(idle_o) && $past(wake))
        else $error("Release without a wake in idle.");

    // Each source, pending and enabled with the global enable on, wakes.
    src_wake_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (idle_o && glob_en_i && (wake_i.pend & wake_i.en) != '0)
        |=> irq_release_o)
        else $error("Enabled source did not wake the core.");

    // With the global enable off no source may end idle.
    glob_block_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (idle_o && !glob_en_i) |=> idle_o)
        else $error("Idle left while interrupts were off.");

    // A write whose instruction has not completed never halts the core.
    done_gate_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (state == IPC_RUN && !instr_done_i) |=> !idle_o)
        else $error("Idle entered before the instruction ended.");

    // The core is already running during the release cycle.
    halt_run_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        irq_release_o |-> !cpu_halt_o && !periph_gate_o)
        else $error("Core still halted during release.");

    // Without a new setting write the run state is never left.
    no_reenter_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (state == IPC_RUN && !set_idle) |=> !idle_o)
        else $error("Idle re-entered without a write.");

    // Every write outside the release cycle lands in the register.
    wr_store_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (pcr_wr_i.we && state != IPC_WAKE)
        |=> pcr_rdata_o == $past(pcr_wr_i.wdata))
        else $error("Register write lost.");

    // Main scenarios: entry, wake, a long idle, a blocked wake, a reset.
    enter_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        $rose(idle_o));
    wake_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        irq_release_o);
    long_idle_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        idle_o [*5] ##1 irq_release_o);
    blocked_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        idle_o && !glob_en_i && (wake_i.pend & wake_i.en) != '0);
    reset_idle_c: cover property (@(posedge clock_i)
        idle_o ##1 !rst_n_i);

endmodule

// ### hw/ipc_pkg.sv
package ipc_pkg;

    // Bit of the power control register that requests idle mode.
    localparam int unsigned IPC_IDLE_BIT = 0;
    // Reset value of the power control register.
    localparam logic [7:0] IPC_PCR_RESET = 8'h00;
    // Number of wake sources: external 0/1, watchdog, auxiliary.
    localparam int unsigned IPC_NUM_SRC = 4;

    // Write port from the CPU core into the power control register.
    typedef struct packed {
        logic       we;
        logic [7:0] wdata;
    } ipc_pcr_wr_t;

    // Wake sources, each a pending and enabled pair.
    typedef struct packed {
        logic [IPC_NUM_SRC-1:0] pend;
        logic [IPC_NUM_SRC-1:0] en;
    } ipc_wake_t;

    // Power sequencer states.
    typedef enum logic [1:0] {
        IPC_RUN,
        IPC_IDLE,
        IPC_WAKE
    } ipc_state_t;

endpackage

// ### hw/ipc_wake_detect.sv
`timescale 1ns/10ps
// Reduces the wake sources to one level: any source pending and enabled, while the global enable is on.
module ipc_wake_detect
    import ipc_pkg::*;
(
    // Wake sources.
    input  wire ipc_wake_t wake_i,
    input  wire logic      glob_en_i,
    // Combined wake request.
    output logic           wake_o
);

    // Global enable gates every source, as in the interrupt controller.
    assign wake_o = glob_en_i & (|(wake_i.pend & wake_i.en));

endmodule

// ### test/ipc_irq_model.sv
`timescale 1ns/10ps
// Interrupt controller stand-in: a fired source stays pending until the
// core is released to serve it, so a late enable still finds it.
module ipc_irq_model
    import ipc_pkg::*;
(
    // Clock and reset.
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    // Stimulus and service acknowledge.
    input  wire logic [3:0] fire_i,
    input  wire logic [3:0] en_i,
    input  wire logic       irq_release_i,
    // Wake sources to the sequencer.
    output ipc_wake_t       wake_o
);
    logic [3:0] pend;

    // The service routine runs on release and clears every pending flag.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend <= 4'h0;
        end else begin
            pend <= (pend | fire_i) & ~{4{irq_release_i}};
        end
    end

    // Enables come straight from the bench.
    assign wake_o = '{pend: pend, en: en_i};
endmodule

// ### test/idle_mode_power_control_test.sv
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module idle_mode_power_control_test
    import ipc_pkg::*;
;
    logic        clock_i = 0, rst_n_i = 0, glob_en_i = 1, done = 1;
    logic        halt, gate, rel, idle;
    logic [3:0]  fire = 4'h0, en = 4'h0;
    logic [7:0]  rdata;
    ipc_pcr_wr_t pcr_wr = '0;
    ipc_wake_t   wake;
    int          error_cnt = 0, num_checks = 0, cyc = 0, k;

    // Free-running clock and a cycle ceiling against hangs.
    always #10 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 500) begin
            error_cnt++;
            finish_test();
        end
    end

    ipc_power_ctrl ipc_power_ctrl_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .pcr_wr_i(pcr_wr), .pcr_rdata_o(rdata), .instr_done_i(done),
        .cpu_halt_o(halt), .periph_gate_o(gate), .wake_i(wake),
        .glob_en_i(glob_en_i), .irq_release_o(rel), .idle_o(idle));
    ipc_irq_model ipc_irq_model_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .fire_i(fire), .en_i(en), .irq_release_i(rel), .wake_o(wake));

    // One-cycle write strobe; returns just after the taking edge.
    // The instruction-end marker travels with the write strobe.
    task automatic wr(input logic [7:0] d, input logic c);
        @(posedge clock_i) begin
            pcr_wr <= '{we: 1'b1, wdata: d};
            done   <= c;
        end
        @(posedge clock_i) begin
            pcr_wr <= '{we: 1'b0, wdata: 8'h00};
            done   <= 1'b1;
        end
        #1;
    endtask

    task automatic t_enter();
        wr(8'h01, 1'b0);
        `CHK(idle, 1'b0)
        `CHK(rdata, 8'h01)
        wr(8'h02, 1'b1);
        `CHK(idle, 1'b0)
        wr(8'h01, 1'b1);
        `CHK(idle, 1'b1)
        `CHK(halt, 1'b1)
        `CHK(gate, 1'b1)
        `CHK(rdata, 8'h01)
        $display("test enter done");
    endtask

    // A pending source wakes only once both its enable and global are on.
    task automatic t_wake(input int s);
        wr(8'h01, 1'b1);
        @(posedge clock_i) fire <= 4'h1 << s;
        @(posedge clock_i) fire <= 4'h0;
        repeat (3) @(posedge clock_i);
        #1 `CHK(idle, 1'b1)
        @(posedge clock_i) en <= 4'h1 << s;
        glob_en_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        #1 `CHK(idle, 1'b1)
        @(posedge clock_i) glob_en_i <= 1'b1;
        k = 0;
        while (rel !== 1'b1 && k < 8) begin
            @(posedge clock_i);
            #1 k++;
        end
        `CHK(rel, 1'b1)
        `CHK(idle, 1'b0)
        @(posedge clock_i) en <= 4'h0;
        #1 `CHK(rel, 1'b0)
        `CHK(halt, 1'b0)
        `CHK(gate, 1'b0)
        `CHK(rdata[0], 1'b0)
        $display("test wake %0d done", s);
    endtask

    task automatic t_reset();
        wr(8'h01, 1'b1);
        @(posedge clock_i) rst_n_i <= 1'b0;
        @(posedge clock_i) rst_n_i <= 1'b1;
        #1 `CHK(idle, 1'b0)
        `CHK(rdata, 8'h00)
        `CHK(halt, 1'b0)
        `CHK(gate, 1'b0)
        $display("test reset done");
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Two cycles of reset, then every scenario in turn.
    initial begin
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        t_enter();
        for (int s = 0; s < 4; s++) begin
            t_wake(s);
        end
        t_reset();
        finish_test();
    end
endmodule
